// File: design/fdp_data_phase.sv
// Data-phase signalling of one front side bus agent: busy, data valid, parity, postpone input.
// Assumes the bus pins arrive asynchronously and are resolved outside from the output enables.
// ----------------------------------------------------------------------------
// Function
// [RULE1] The data driver holds busy asserted while it uses the bus, and the bus is free only after busy deasserts.
// [RULE2] An agent asserts postpone when a transaction cannot be guaranteed in-order completion; here it is an input.
// [RULE3] The addressed memory or I/O agent, not this agent, normally asserts postpone.
// [RULE4] Four parity lines protect all 64 data lines and are valid with each data transfer.
// [RULE5] Only the agent driving the data bus drives the parity lines.
// [RULE6] The driver asserts data valid on each transfer and may deassert it to insert idle clocks.
// [RULE7] Each parity line is even parity over one 16-bit group, and receivers check it against their own.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "fdp_params.svh"

module fdp_data_phase
   import fdp_pkg::*;
#(
   parameter int DATA_W = `FDP_DATA_W,
   parameter int GROUPS = `FDP_GROUPS
)
(
   input wire logic mclk_i,
   input wire logic srst_i,
   // Local side
   input wire logic xfer_start_i,
   input wire logic [`FDP_XFER_CNT_W-1:0] xfer_beats_i,
   input wire logic beat_ok_i,
   input wire logic [DATA_W-1:0] tx_data_i,
   output logic beat_taken_o,
   output logic xfer_busy_o,
   output logic [DATA_W-1:0] rx_data_o,
   output logic rx_valid_o,
   output logic parity_err_o,
   output logic postpone_o,
   output logic bus_free_o,
   // Bus pins, active low
   input wire logic data_bus_busy_n_i,
   output logic data_bus_busy_n_o,
   output logic data_bus_busy_n_oe_o,
   input wire logic data_valid_n_i,
   output logic data_valid_n_o,
   output logic data_valid_n_oe_o,
   input wire logic [DATA_W-1:0] data_n_i,
   output logic [DATA_W-1:0] data_n_o,
   output logic data_n_oe_o,
   input wire logic [GROUPS-1:0] data_parity_n_i,
   output logic [GROUPS-1:0] data_parity_n_o,
   output logic data_parity_n_oe_o,
   input wire logic txn_postpone_n_i
);

   // ----------------------------------------------------------------------------
   // Parity helper
   // ----------------------------------------------------------------------------
   function automatic logic [GROUPS-1:0] group_parity(input logic [DATA_W-1:0] d);
      logic [GROUPS-1:0] p;
      p = '0;
      for (int g = 0; g < GROUPS; g++)
      begin
         p[g] = ^d[g*`FDP_GROUP_W +: `FDP_GROUP_W]; // [RULE7]
      end
      return p;
   endfunction

   // ----------------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------------
   logic [DATA_W+GROUPS+2:0] sync1_reg;
   logic [DATA_W+GROUPS+2:0] sync2_reg;

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end
      else
      begin
         sync1_reg <= {txn_postpone_n_i, data_bus_busy_n_i, data_valid_n_i, data_parity_n_i, data_n_i};
         sync2_reg <= sync1_reg;
      end
   end

   logic [DATA_W-1:0] s_data;
   logic [GROUPS-1:0] s_par;
   logic s_valid;
   logic s_busy;
   logic s_postpone;
   assign s_data = ~sync2_reg[DATA_W-1:0];
   assign s_par = ~sync2_reg[DATA_W +: GROUPS];
   assign s_valid = ~sync2_reg[DATA_W+GROUPS];
   assign s_busy = ~sync2_reg[DATA_W+GROUPS+1];
   assign s_postpone = ~sync2_reg[DATA_W+GROUPS+2];

   // ----------------------------------------------------------------------------
   // Transmit state machine
   // ----------------------------------------------------------------------------
   fdp_state_type state_reg;
   logic [`FDP_XFER_CNT_W-1:0] beats_reg;
   logic drive_beat;

   assign xfer_busy_o = (state_reg != FDP_IDLE);
   assign drive_beat = xfer_busy_o && beat_ok_i;
   assign beat_taken_o = drive_beat;

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         state_reg <= FDP_IDLE;
         beats_reg <= '0;
      end
      else
      begin
         case (state_reg)
            FDP_IDLE:
            begin
               if (xfer_start_i && bus_free_o) // [RULE1]
               begin
                  state_reg <= FDP_XFER;
                  beats_reg <= (xfer_beats_i == '0) ? `FDP_DEF_BEATS : xfer_beats_i;
               end
            end
            FDP_XFER, FDP_GAP:
            begin
               if (drive_beat)
               begin
                  beats_reg <= beats_reg - 1'b1;
                  if (beats_reg == 4'h1)
                     state_reg <= FDP_IDLE;
                  else
                     state_reg <= FDP_XFER;
               end
               else
               begin
                  state_reg <= FDP_GAP; // [RULE6]
               end
            end
            default:
            begin
               state_reg <= FDP_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         data_bus_busy_n_o <= 1'b1;
         data_bus_busy_n_oe_o <= 1'b0;
         data_valid_n_o <= 1'b1;
         data_valid_n_oe_o <= 1'b0;
         data_n_o <= '1;
         data_n_oe_o <= 1'b0;
         data_parity_n_o <= '1;
         data_parity_n_oe_o <= 1'b0;
      end
      else
      begin
         data_bus_busy_n_o <= ~xfer_busy_o; // [RULE1]
         data_bus_busy_n_oe_o <= xfer_busy_o; // [RULE1]
         data_valid_n_o <= ~drive_beat; // [RULE6]
         data_valid_n_oe_o <= xfer_busy_o;
         data_n_oe_o <= xfer_busy_o;
         data_parity_n_oe_o <= xfer_busy_o; // [RULE5]
         if (drive_beat)
         begin
            data_n_o <= ~tx_data_i;
            data_parity_n_o <= ~group_parity(tx_data_i); // [RULE4]
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Own-drive echo mask
   // ----------------------------------------------------------------------------
   logic echo1_reg;
   logic echo2_reg;
   logic rx_take;

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         echo1_reg <= 1'b0;
         echo2_reg <= 1'b0;
      end
      else
      begin
         echo1_reg <= data_valid_n_oe_o;
         echo2_reg <= echo1_reg;
      end
   end

   // Own beats return through the synchronisers two clocks late; keep them out of the receive path
   assign rx_take = s_valid && !xfer_busy_o && !echo2_reg; // [RULE6]

   // ----------------------------------------------------------------------------
   // Receive side
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         rx_data_o <= '0;
         rx_valid_o <= 1'b0;
         parity_err_o <= 1'b0;
         postpone_o <= 1'b0;
         bus_free_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= rx_take; // [RULE6]
         parity_err_o <= rx_take && (group_parity(s_data) != s_par); // [RULE7]
         if (rx_take)
            rx_data_o <= s_data;
         postpone_o <= s_postpone; // [RULE2]
         bus_free_o <= !s_busy && !xfer_busy_o; // [RULE1]
      end
   end

endmodule
`default_nettype wire

// File: pkg/fdp_params.svh
// Constants for the front side bus data-phase signalling block.
// Assumes inclusion by bare name from the package and design files.
`ifndef FDP_PARAMS_SVH
`define FDP_PARAMS_SVH

`define FDP_DATA_W 64
`define FDP_GROUP_W 16
`define FDP_GROUPS 4
`define FDP_XFER_CNT_W 4
`define FDP_DEF_BEATS 4'h4

`endif

// File: pkg/fdp_pkg.sv
// Types for the front side bus data-phase signalling block.
// Assumes fdp_params.svh is on the include path.
`include "fdp_params.svh"

package fdp_pkg;
   typedef enum logic [1:0] {
      FDP_IDLE,
      FDP_XFER,
      FDP_GAP
   } fdp_state_type;
endpackage

// File: tb/fdp_agent_model.sv
// Model of another bus agent: one data beat, postpone.
// Assumes wired-low pins with pull-ups; released pins read 1.
`timescale 1ns/1ps
`default_nettype none
module fdp_agent_model(
   input wire logic mclk_i,
   output logic busy_n_o,
   output logic valid_n_o,
   output logic [63:0] data_n_o,
   output logic [3:0] par_n_o,
   output logic postpone_n_o
);
   initial
   begin
      {busy_n_o, valid_n_o, data_n_o, par_n_o, postpone_n_o} = '1;
   end
   // Drives one beat for a cycle, then releases
   task send(input logic [63:0] d, input logic bad);
      busy_n_o = 1'b0;
      valid_n_o = 1'b0;
      data_n_o = ~d;
      par_n_o = ~{^d[63:48], ^d[47:32], ^d[31:16], ^d[15:0]} ^ {3'h0, bad};
      @(negedge mclk_i);
      {busy_n_o, valid_n_o, data_n_o, par_n_o} = '1;
   endtask
   task postpone(input logic on);
      postpone_n_o = !on;
   endtask
endmodule
`default_nettype wire

// File: tb/fdp_props_properties.sv
// Checker for the data-phase pin outputs and the postpone and parity error flags.
// Assumes binding onto fdp_data_phase ports.
`timescale 1ns/1ps
`default_nettype none
module fdp_props(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic beat_taken_o,
   input wire logic rx_valid_o,
   input wire logic parity_err_o,
   input wire logic postpone_o,
   input wire logic txn_postpone_n_i,
   input wire logic data_bus_busy_n_o,
   input wire logic data_valid_n_o,
   input wire logic data_valid_n_oe_o,
   input wire logic [63:0] data_n_o,
   input wire logic data_n_oe_o,
   input wire logic [3:0] data_parity_n_o,
   input wire logic data_parity_n_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   property p_busy; data_valid_n_oe_o && !data_valid_n_o |-> !data_bus_busy_n_o; endproperty
   a_busy: assert property (p_busy) else $error("valid without busy");
   property p_post; $fell(txn_postpone_n_i) |-> ##[1:4] postpone_o; endproperty
   a_post: assert property (p_post) else $error("postpone lost");
   property p_par; data_parity_n_oe_o |-> data_parity_n_o == ~{^data_n_o[63:48], ^data_n_o[47:32],
      ^data_n_o[31:16], ^data_n_o[15:0]}; endproperty
   a_par: assert property (p_par) else $error("bad parity");
   property p_own; data_parity_n_oe_o == data_n_oe_o; endproperty
   a_own: assert property (p_own) else $error("parity owner");
   property p_valid; beat_taken_o |=> !data_valid_n_o && data_valid_n_oe_o; endproperty
   a_valid: assert property (p_valid) else $error("no valid");
   property p_err; parity_err_o |-> rx_valid_o; endproperty
   a_err: assert property (p_err) else $error("stray error");
endmodule
bind fdp_data_phase fdp_props i_props (
   .mclk_i(mclk_i),
   .srst_i(srst_i),
   .beat_taken_o(beat_taken_o),
   .rx_valid_o(rx_valid_o),
   .parity_err_o(parity_err_o),
   .postpone_o(postpone_o),
   .txn_postpone_n_i(txn_postpone_n_i),
   .data_bus_busy_n_o(data_bus_busy_n_o),
   .data_valid_n_o(data_valid_n_o),
   .data_valid_n_oe_o(data_valid_n_oe_o),
   .data_n_o(data_n_o),
   .data_n_oe_o(data_n_oe_o),
   .data_parity_n_o(data_parity_n_o),
   .data_parity_n_oe_o(data_parity_n_oe_o)
);
`default_nettype wire

// File: tb/tb_top.sv
// Bench for fdp_data_phase with one partner agent.
// Assumes wired-low pins with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk_i = 0, srst_i = 1, xfer_start_i = 0, beat_ok_i = 0;
   logic [3:0] xfer_beats_i = 0;
   logic [63:0] tx_data_i = 0, rx_data_o, data_n_o;
   logic [3:0] data_parity_n_o;
   logic beat_taken_o, xfer_busy_o, rx_valid_o, parity_err_o, postpone_o, bus_free_o, data_n_oe_o;
   logic data_bus_busy_n_o, data_bus_busy_n_oe_o, data_valid_n_o, data_valid_n_oe_o, data_parity_n_oe_o;
   wire mb, mv, txn_postpone_n_i;
   wire [63:0] md;
   wire [3:0] mp;
   wire data_bus_busy_n_i = (data_bus_busy_n_oe_o ? data_bus_busy_n_o : 1'b1) & mb;
   wire data_valid_n_i = (data_valid_n_oe_o ? data_valid_n_o : 1'b1) & mv;
   wire [63:0] data_n_i = (data_n_oe_o ? data_n_o : '1) & md;
   wire [3:0] data_parity_n_i = (data_parity_n_oe_o ? data_parity_n_o : '1) & mp;
   int err_count = 0, checks = 0, cyc = 0;
   fdp_data_phase i_dut (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .xfer_start_i(xfer_start_i),
      .xfer_beats_i(xfer_beats_i),
      .beat_ok_i(beat_ok_i),
      .tx_data_i(tx_data_i),
      .beat_taken_o(beat_taken_o),
      .xfer_busy_o(xfer_busy_o),
      .rx_data_o(rx_data_o),
      .rx_valid_o(rx_valid_o),
      .parity_err_o(parity_err_o),
      .postpone_o(postpone_o),
      .bus_free_o(bus_free_o),
      .data_bus_busy_n_i(data_bus_busy_n_i),
      .data_bus_busy_n_o(data_bus_busy_n_o),
      .data_bus_busy_n_oe_o(data_bus_busy_n_oe_o),
      .data_valid_n_i(data_valid_n_i),
      .data_valid_n_o(data_valid_n_o),
      .data_valid_n_oe_o(data_valid_n_oe_o),
      .data_n_i(data_n_i),
      .data_n_o(data_n_o),
      .data_n_oe_o(data_n_oe_o),
      .data_parity_n_i(data_parity_n_i),
      .data_parity_n_o(data_parity_n_o),
      .data_parity_n_oe_o(data_parity_n_oe_o),
      .txn_postpone_n_i(txn_postpone_n_i)
   );
   fdp_agent_model i_agent (.mclk_i, .busy_n_o(mb), .valid_n_o(mv), .data_n_o(md), .par_n_o(mp),
      .postpone_n_o(txn_postpone_n_i));
   always #20 mclk_i = ~mclk_i;
   task test_done;
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 500)
      begin
         err_count++;
         test_done();
      end
   end
   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1)
      begin
         $display("CHECK FAILED %0t %s", $time, m);
         err_count++;
      end
   endtask
   // Two beats with an idle clock before the first
   task t_tx;
      while (bus_free_o !== 1'b1) @(negedge mclk_i);
      xfer_start_i = 1;
      xfer_beats_i = 4'h2;
      tx_data_i = 64'h1234_5678_9abc_def0;
      @(negedge mclk_i);
      xfer_start_i = 0;
      chk(xfer_busy_o === 1'b1, "owning");
      @(negedge mclk_i);
      chk(data_bus_busy_n_i === 1'b0, "busy");
      chk(data_valid_n_i === 1'b1, "gap");
      beat_ok_i = 1;
      @(negedge mclk_i);
      chk(data_valid_n_i === 1'b0 && data_n_i === ~tx_data_i && beat_taken_o === 1'b1, "beat 1");
      tx_data_i = 64'h0000_ffff_0f0f_0001;
      @(negedge mclk_i);
      chk(data_n_i === ~tx_data_i && data_parity_n_oe_o === 1'b1, "beat 2");
      beat_ok_i = 0;
      @(negedge mclk_i);
      chk(data_bus_busy_n_i === 1'b1 && data_valid_n_i === 1'b1 && bus_free_o === 1'b0, "release");
   endtask
   // Beat count zero runs four beats
   task t_def;
      int n;
      n = 0;
      while (bus_free_o !== 1'b1) @(negedge mclk_i);
      xfer_start_i = 1;
      xfer_beats_i = 4'h0;
      beat_ok_i = 1;
      @(negedge mclk_i);
      xfer_start_i = 0;
      repeat (6)
      begin
         if (beat_taken_o === 1'b1)
            n++;
         @(negedge mclk_i);
      end
      beat_ok_i = 0;
      chk(n == 4 && xfer_busy_o === 1'b0, "default beats");
   endtask
   // Receive one beat from the partner
   task t_rx(input logic [63:0] d, input logic bad);
      int n;
      n = 0;
      @(negedge mclk_i);
      i_agent.send(d, bad);
      while (rx_valid_o !== 1'b1 && n < 8)
      begin
         @(negedge mclk_i);
         n++;
      end
      chk(rx_valid_o === 1'b1 && rx_data_o === d, "rx data");
      chk(parity_err_o === bad, "parity flag");
   endtask
   task t_post;
      i_agent.postpone(1);
      repeat (5) @(negedge mclk_i);
      chk(postpone_o === 1'b1, "postpone on");
      i_agent.postpone(0);
      repeat (5) @(negedge mclk_i);
      chk(postpone_o === 1'b0, "postpone off");
   endtask
   initial
   begin
      repeat (3) @(negedge mclk_i);
      srst_i = 0;
      t_tx;
      t_rx(64'h0f0f_0000_ffff_1234, 1'b0);
      t_rx(64'h8001_7ffe_0000_c3c3, 1'b1);
      t_post;
      t_def;
      test_done;
   end
endmodule
`default_nettype wire
